//--- bench/uart_irq_level_and_mask_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module uart_irq_level_and_mask_asserts #(
  parameter int FIFO_DEPTH = 64,
  parameter int LEVEL_W = 7
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic [LEVEL_W-1:0] txFifoCount,
  input wire logic [LEVEL_W-1:0] rxFifoCount,
  input wire uart_irq_pkg::uart_events_s events,
  input wire logic [2:0] txTriggerSel,
  input wire logic [2:0] rxTriggerSel,
  input wire logic uartIrq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic lvlWr;
  logic maskWr;
  assign lvlWr = regWr && regAddr == uart_irq_pkg::OFS_TRIGGER_LEVELS;
  assign maskWr = regWr && regAddr == uart_irq_pkg::OFS_ENABLE_MASK;
  level_reset_a: assert property ($rose(nrst) |-> txTriggerSel == 3'h2 && rxTriggerSel == 3'h2)
    else $error("level selects not at reset value");
  tx_sel_write_a: assert property (lvlWr |=> txTriggerSel == $past(regWdata[2:0]))
    else $error("tx level select not written");
  rx_sel_write_a: assert property (lvlWr |=> rxTriggerSel == $past(regWdata[5:3]))
    else $error("rx level select not written");
  sel_hold_a: assert property (!lvlWr |=> $stable(txTriggerSel) && $stable(rxTriggerSel))
    else $error("level select changed without a write");
  read_idle_a: assert property (!regRd |=> regRdata == 32'h0)
    else $error("read data outside read cycle");
  mask_readback_a: assert property (maskWr ##2 (regRd && regAddr == uart_irq_pkg::OFS_ENABLE_MASK)
    |=> regRdata == ($past(regWdata, 3) & 32'h1FF2))
    else $error("mask read back wrong");
  mask_quiet_a: assert property (maskWr && regWdata == 32'h0 |=> !uartIrq)
    else $error("interrupt with all sources masked");
  clear_read_a: assert property (regRd && regAddr == uart_irq_pkg::OFS_CLEAR |=> regRdata == 32'h0)
    else $error("clear register read not zero");
endmodule : uart_irq_level_and_mask_asserts
bind uart_irq_level_and_mask uart_irq_level_and_mask_asserts #(.FIFO_DEPTH(FIFO_DEPTH),
  .LEVEL_W(LEVEL_W)) chk (.ref_clk, .nrst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
  .txFifoCount, .rxFifoCount, .events, .txTriggerSel, .rxTriggerSel, .uartIrq);
`default_nettype wire

//--- bench/uart_irq_level_and_mask_tb.sv
`timescale 1ns/10ps
`default_nettype none
module uart_irq_level_and_mask_tb;
  logic ref_clk = 1'h0;
  logic nrst = 1'h0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'h0;
  logic regRd = 1'h0;
  logic [31:0] regRdata;
  // TX FIFO starts full so no level or empty flag fires at release
  logic [6:0] txFifoCount = 7'h40;
  logic [6:0] rxFifoCount = 7'h00;
  uart_irq_pkg::uart_events_s events = '0;
  logic [2:0] txTriggerSel;
  logic [2:0] rxTriggerSel;
  logic uartIrq;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  uart_irq_level_and_mask dut (.ref_clk, .nrst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .txFifoCount, .rxFifoCount, .events, .txTriggerSel, .rxTriggerSel, .uartIrq);
  initial forever #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWr <= 1'h0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge ref_clk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'h0;
    #1;
    chk(what, exp, regRdata);
  endtask : rd
  task automatic t_levels();
    for (int i = 0; i < 8; i++) begin
      wr(8'h34, 32'(i) | 32'(7 - i) << 3);
      chk("tx sel", 32'(i), {29'h0, txTriggerSel});
      chk("rx sel", 32'(7 - i), {29'h0, rxTriggerSel});
      rd(8'h34, 32'(i) | 32'(7 - i) << 3, "levels");
    end
    wr(8'h34, 32'h12);
    $display("level select test done");
  endtask : t_levels
  task automatic t_events();
    // Event bit 0 is flow stop, bit 6 clear-to-send change
    int pos[7] = '{11, 10, 9, 8, 7, 6, 1};
    for (int i = 0; i < 7; i++) begin
      @(posedge ref_clk);
      events <= uart_irq_pkg::uart_events_s'(7'h01 << i);
      @(posedge ref_clk);
      events <= '0;
      rd(8'h3C, 32'h1 << pos[i], "raw");
      chk("irq masked", 32'h0, {31'h0, uartIrq});
      wr(8'h38, 32'h1 << pos[i]);
      chk("irq", 32'h1, {31'h0, uartIrq});
      rd(8'h40, 32'h1 << pos[i], "masked");
      wr(8'h44, 32'h1 << pos[i]);
      chk("irq cleared", 32'h0, {31'h0, uartIrq});
      rd(8'h3C, 32'h0, "raw cleared");
      wr(8'h38, 32'h0);
    end
    $display("event test done");
  endtask : t_events
  task automatic t_fifo();
    // Reset selects: RX fires at 8 of 64 full, TX at 4 of 64 free
    @(posedge ref_clk);
    rxFifoCount <= 7'h07;
    txFifoCount <= 7'h3D;
    repeat (3) @(posedge ref_clk);
    rd(8'h3C, 32'h0, "below levels");
    @(posedge ref_clk);
    rxFifoCount <= 7'h08;
    txFifoCount <= 7'h3C;
    repeat (3) @(posedge ref_clk);
    rd(8'h3C, 32'h30, "at levels");
    wr(8'h38, 32'h30);
    chk("level irq", 32'h1, {31'h0, uartIrq});
    wr(8'h44, 32'h10);
    rd(8'h40, 32'h20, "one cleared");
    wr(8'h44, 32'h20);
    // RX code 001b fires at 4 of 64 full
    wr(8'h34, 32'h0A);
    @(posedge ref_clk);
    rxFifoCount <= 7'h03;
    repeat (3) @(posedge ref_clk);
    rd(8'h3C, 32'h0, "rx below sixteenth");
    @(posedge ref_clk);
    rxFifoCount <= 7'h04;
    repeat (3) @(posedge ref_clk);
    rd(8'h3C, 32'h10, "rx at sixteenth");
    wr(8'h44, 32'h10);
    // TX level already reached, so emptying raises only the empty flag
    @(posedge ref_clk);
    txFifoCount <= 7'h00;
    repeat (3) @(posedge ref_clk);
    rd(8'h3C, 32'h1000, "tx empty raw");
    wr(8'h38, 32'h1000);
    chk("empty irq", 32'h1, {31'h0, uartIrq});
    wr(8'h44, 32'h1000);
    chk("empty cleared", 32'h0, {31'h0, uartIrq});
    wr(8'h38, 32'h0);
    wr(8'h34, 32'h12);
    $display("fifo level test done");
  endtask : t_fifo
  initial begin
    repeat (2) @(posedge ref_clk);
    nrst <= 1'h1;
    rd(8'h34, 32'h12, "reset levels");
    rd(8'h38, 32'h0, "reset mask");
    rd(8'h3C, 32'h0, "reset raw");
    wr(8'h38, 32'hFFFFFFFF);
    rd(8'h38, 32'h1FF2, "mask all");
    wr(8'h38, 32'h0);
    chk("irq off", 32'h0, {31'h0, uartIrq});
    rd(8'h38, 32'h0, "mask none");
    rd(8'h44, 32'h0, "clear read");
    $display("register test done");
    t_levels();
    t_events();
    t_fifo();
    conclude();
  end
endmodule : uart_irq_level_and_mask_tb
`default_nettype wire

//--- logic/fifo_level_compare.sv
`timescale 1ns/10ps
`default_nettype none
// Decides whether a FIFO count reaches a fraction of its depth.
module fifo_level_compare #(
  parameter int LEVEL_W = 7,
  parameter int DEPTH = 64
) (
  // Selection and count
  input wire logic [2:0] sel,
  input wire logic [LEVEL_W-1:0] count,
  // Result
  output logic reached
);

  logic [LEVEL_W+1:0] scaled;
  logic [LEVEL_W+1:0] thresh;

  // Compare count*4 against depth*num/den*4 so 3/4 needs no division
  always_comb begin
    scaled = {count, 2'b00};
    case (sel)
      uart_irq_pkg::LVL_1_64: thresh = (LEVEL_W + 2)'(DEPTH / 16);
      uart_irq_pkg::LVL_1_32: thresh = (LEVEL_W + 2)'(DEPTH / 8);
      uart_irq_pkg::LVL_1_16: thresh = (LEVEL_W + 2)'(DEPTH / 4);
      uart_irq_pkg::LVL_1_8: thresh = (LEVEL_W + 2)'(DEPTH / 2);
      uart_irq_pkg::LVL_1_4: thresh = (LEVEL_W + 2)'(DEPTH);
      uart_irq_pkg::LVL_1_2: thresh = (LEVEL_W + 2)'(DEPTH * 2);
      uart_irq_pkg::LVL_3_4: thresh = (LEVEL_W + 2)'(DEPTH * 3);
      default: thresh = (LEVEL_W + 2)'(DEPTH * 3);
    endcase
    reached = (scaled >= thresh);
  end

endmodule : fifo_level_compare
`default_nettype wire

//--- logic/uart_irq_level_and_mask.sv
// Chosen here: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// R01: TX level select in bits 2:0 picks empty fraction 1/64 up to 3/4.
// R02: TX level select resets to 2, firing at one sixteenth empty.
// R03: RX level select in bits 5:3 picks full fraction 1/64 up to 3/4.
// R04: RX level select resets to 2, firing at one eighth full.
// R05: Mask bits read back, 1 enables, 0 disables, all reset to 0.
// R06: Mask bit 1 enables the clear-to-send change interrupt.
// R07: Mask bit 4 enables the receive level interrupt.
// R08: Mask bit 5 enables the transmit level interrupt.
// R09: Mask bit 6 enables the receive timeout interrupt.
// R10: Mask bit 7 enables the framing error interrupt.
// R11: Mask bit 8 enables the parity error interrupt.
// R12: Mask bit 9 enables the break error interrupt.
// R13: Mask bit 10 enables the overrun error interrupt.
// R14: Mask bit 11 enables the flow-stop interrupt; bit 12 follows.
// R15: Mask bit 12 enables TX FIFO empty; bits 31:13 reserved.
// R16: Read-only raw status shows pending sources at mask bit positions.
// R17: Writing 1 to a clear bit clears that pending flag; 0 does nothing.
// R18: Masked status is raw AND mask; interrupt output is OR of masked.
// R19: Raw flags set on events regardless of mask.
module uart_irq_level_and_mask #(
  parameter int FIFO_DEPTH = 64,
  parameter int LEVEL_W = 7
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // FIFO fill levels
  input wire logic [LEVEL_W-1:0] txFifoCount,
  input wire logic [LEVEL_W-1:0] rxFifoCount,
  // Raw event pulses
  input wire uart_irq_pkg::uart_events_s events,
  // Outputs to the UART
  output logic [2:0] txTriggerSel,
  output logic [2:0] rxTriggerSel,
  output logic uartIrq
);

  logic [uart_irq_pkg::SRC_W-1:0] mask;
  logic [uart_irq_pkg::SRC_W-1:0] rawFlags;
  logic [uart_irq_pkg::SRC_W-1:0] setVec;
  logic [uart_irq_pkg::SRC_W-1:0] clrVec;
  logic [uart_irq_pkg::SRC_W-1:0] maskedFlags;
  logic [LEVEL_W-1:0] txFree;
  logic txLevelHit;
  logic rxLevelHit;
  logic txLevelHitPrev;
  logic rxLevelHitPrev;
  logic txEmpty;
  logic txEmptyPrev;
  logic [31:0] next_regRdata;
  uart_irq_pkg::reg_req_s req;
  logic [2:0] rxCompareSel;
  logic txLevelRise;
  logic rxLevelRise;
  logic txEmptyRise;
  logic levelsHit;
  logic maskHit;
  logic rawHit;
  logic maskedHit;
  logic clearHit;
  logic levelsWr;
  logic maskWr;
  logic clearWr;
  logic [31:0] levelsWord;
  logic [31:0] maskWord;
  logic [31:0] rawWord;
  logic [31:0] maskedWord;

  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  // Exact byte decode; any other address is ignored on write and reads zero
  assign levelsHit = (req.addr == uart_irq_pkg::OFS_TRIGGER_LEVELS);
  assign maskHit = (req.addr == uart_irq_pkg::OFS_ENABLE_MASK);
  assign rawHit = (req.addr == uart_irq_pkg::OFS_RAW_STATUS);
  assign maskedHit = (req.addr == uart_irq_pkg::OFS_MASKED_STATUS);
  assign clearHit = (req.addr == uart_irq_pkg::OFS_CLEAR);
  assign levelsWr = req.wr && levelsHit;
  assign maskWr = req.wr && maskHit;
  assign clearWr = req.wr && clearHit;

  // Transmit trigger level select
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      txTriggerSel <= uart_irq_pkg::TX_SEL_RESET; // R02
    end else if (levelsWr) begin
      txTriggerSel <= req.wdata[uart_irq_pkg::TX_SEL_LSB +: uart_irq_pkg::SEL_W]; // R01
    end
  end

  // Receive trigger level select
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rxTriggerSel <= uart_irq_pkg::RX_SEL_RESET; // R04
    end else if (levelsWr) begin
      rxTriggerSel <= req.wdata[uart_irq_pkg::RX_SEL_LSB +: uart_irq_pkg::SEL_W]; // R03
    end
  end

  // Mask register; unimplemented positions stay zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mask <= uart_irq_pkg::MASK_RESET; // R05
    end else if (maskWr) begin
      mask <= req.wdata[uart_irq_pkg::SRC_W-1:0] & uart_irq_pkg::SRC_IMPLEMENTED; // R05 R15
    end
  end

  // A count above the depth would wrap the free space, so it reads as no room
  always_comb begin
    if (txFifoCount > LEVEL_W'(FIFO_DEPTH)) begin
      txFree = '0;
    end else begin
      txFree = LEVEL_W'(FIFO_DEPTH) - txFifoCount;
    end
  end
  assign txEmpty = (txFifoCount == '0);

  // Receive codes run on their own scale; map each onto the shared comparator
  // Codes 011b and 100b are not told apart, so both take one quarter
  always_comb begin
    case (rxTriggerSel) // R03
      3'h0: rxCompareSel = uart_irq_pkg::LVL_1_64;
      3'h1: rxCompareSel = uart_irq_pkg::LVL_1_16;
      3'h2: rxCompareSel = uart_irq_pkg::LVL_1_8;
      3'h3: rxCompareSel = uart_irq_pkg::LVL_1_4;
      3'h4: rxCompareSel = uart_irq_pkg::LVL_1_4;
      3'h5: rxCompareSel = uart_irq_pkg::LVL_1_2;
      3'h6: rxCompareSel = uart_irq_pkg::LVL_3_4;
      default: rxCompareSel = uart_irq_pkg::LVL_3_4;
    endcase
  end

  fifo_level_compare #(
    .LEVEL_W(LEVEL_W),
    .DEPTH(FIFO_DEPTH)
  ) txCompare (
    .sel(txTriggerSel),
    .count(txFree),
    .reached(txLevelHit)
  ); // R01

  fifo_level_compare #(
    .LEVEL_W(LEVEL_W),
    .DEPTH(FIFO_DEPTH)
  ) rxCompare (
    .sel(rxCompareSel),
    .count(rxFifoCount),
    .reached(rxLevelHit)
  ); // R03

  // Level interrupts fire on crossing, so a cleared flag stays clear until the next crossing
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      txLevelHitPrev <= 1'b0;
    end else begin
      txLevelHitPrev <= txLevelHit;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rxLevelHitPrev <= 1'b0;
    end else begin
      rxLevelHitPrev <= rxLevelHit;
    end
  end

  // Empty history resets low, so a FIFO that is empty at release flags at once
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      txEmptyPrev <= 1'b0;
    end else begin
      txEmptyPrev <= txEmpty;
    end
  end

  assign txLevelRise = txLevelHit && !txLevelHitPrev;
  assign rxLevelRise = rxLevelHit && !rxLevelHitPrev;
  assign txEmptyRise = txEmpty && !txEmptyPrev;

  always_comb begin
    setVec = '0;
    setVec[uart_irq_pkg::BIT_CTS] = events.ctsChange;
    setVec[uart_irq_pkg::BIT_RX] = rxLevelRise;
    setVec[uart_irq_pkg::BIT_TX] = txLevelRise;
    setVec[uart_irq_pkg::BIT_RT] = events.rxTimeout;
    setVec[uart_irq_pkg::BIT_FE] = events.framingErr;
    setVec[uart_irq_pkg::BIT_PE] = events.parityErr;
    setVec[uart_irq_pkg::BIT_BE] = events.breakErr;
    setVec[uart_irq_pkg::BIT_OE] = events.overrunErr;
    setVec[uart_irq_pkg::BIT_XOFF] = events.flowStop;
    setVec[uart_irq_pkg::BIT_TXFE] = txEmptyRise;
  end

  always_comb begin
    clrVec = '0;
    if (clearWr) begin
      clrVec = req.wdata[uart_irq_pkg::SRC_W-1:0]; // R17
    end
  end

  // Set wins over a simultaneous clear so no event is lost
  // Reserved positions are never set, so their flags hold zero from reset
  genvar i;
  generate
    for (i = 0; i < uart_irq_pkg::SRC_W; i++) begin : g_flag
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          rawFlags[i] <= 1'b0;
        end else if (setVec[i]) begin
          rawFlags[i] <= 1'b1; // R19
        end else if (clrVec[i]) begin
          rawFlags[i] <= 1'b0; // R17
        end
      end
    end
  endgenerate

  assign maskedFlags = rawFlags & mask; // R18 R06 R07 R08 R09 R10 R11 R12 R13 R14 R15
  assign uartIrq = |maskedFlags; // R18

  // Readable words; reserved bits read zero
  always_comb begin
    levelsWord = '0;
    levelsWord[uart_irq_pkg::TX_SEL_LSB +: uart_irq_pkg::SEL_W] = txTriggerSel; // R01
    levelsWord[uart_irq_pkg::RX_SEL_LSB +: uart_irq_pkg::SEL_W] = rxTriggerSel; // R03
  end
  assign maskWord = 32'(mask); // R05
  assign rawWord = 32'(rawFlags); // R16
  assign maskedWord = 32'(maskedFlags); // R18

  // Read mux; unmapped addresses and the write-only clear read zero
  always_comb begin
    next_regRdata = '0;
    if (req.rd) begin
      if (levelsHit) begin
        next_regRdata = levelsWord;
      end else if (maskHit) begin
        next_regRdata = maskWord; // R05
      end else if (rawHit) begin
        next_regRdata = rawWord; // R16
      end else if (maskedHit) begin
        next_regRdata = maskedWord; // R18
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      regRdata <= '0;
    end else begin
      regRdata <= next_regRdata;
    end
  end

endmodule : uart_irq_level_and_mask
`default_nettype wire

//--- logic/uart_irq_pkg.sv
package uart_irq_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_TRIGGER_LEVELS = 8'h34;
  localparam logic [7:0] OFS_ENABLE_MASK = 8'h38;
  localparam logic [7:0] OFS_RAW_STATUS = 8'h3C;
  localparam logic [7:0] OFS_MASKED_STATUS = 8'h40;
  localparam logic [7:0] OFS_CLEAR = 8'h44;

  // Trigger level field layout
  localparam int TX_SEL_LSB = 0;
  localparam int RX_SEL_LSB = 3;
  localparam int SEL_W = 3;
  localparam logic [2:0] TX_SEL_RESET = 3'h2;
  localparam logic [2:0] RX_SEL_RESET = 3'h2;

  // Interrupt source bit positions
  localparam int SRC_W = 13;
  localparam int BIT_CTS = 1;
  localparam int BIT_RX = 4;
  localparam int BIT_TX = 5;
  localparam int BIT_RT = 6;
  localparam int BIT_FE = 7;
  localparam int BIT_PE = 8;
  localparam int BIT_BE = 9;
  localparam int BIT_OE = 10;
  localparam int BIT_XOFF = 11;
  localparam int BIT_TXFE = 12;
  localparam logic [12:0] SRC_IMPLEMENTED = 13'h1FF2;
  localparam logic [12:0] MASK_RESET = 13'h0000;

  // Level-select codes
  localparam logic [2:0] LVL_1_64 = 3'h0;
  localparam logic [2:0] LVL_1_32 = 3'h1;
  localparam logic [2:0] LVL_1_16 = 3'h2;
  localparam logic [2:0] LVL_1_8 = 3'h3;
  localparam logic [2:0] LVL_1_4 = 3'h4;
  localparam logic [2:0] LVL_1_2 = 3'h5;
  localparam logic [2:0] LVL_3_4 = 3'h6;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic ctsChange;
    logic rxTimeout;
    logic framingErr;
    logic parityErr;
    logic breakErr;
    logic overrunErr;
    logic flowStop;
  } uart_events_s;

endpackage : uart_irq_pkg
